// >>> rtl/abc_cal_dev.sv
/*
 Device end: calibration sequencer that rotates spare converter cores.
 Assumes a controller on abc_cal_if.dev and a sampleTick enable from
 the sample clock divider on the same core_clk.
*/
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
// Contract
// - Quad: 0,1 share 2; 4,5 share 3.
// - Dual shares 2; single core 0 uses 2.
// - Only one core calibrates at once; the foreground pass calibrates all active cores together.
// - Controller sets background, source 0, soft 1.
// - Controller writes 0x1f and 0x1e delays.
// - Low power: spares off until due.
// - Pacing select: 0 automatic, 1 manual.
// - Automatic: spare sleeps sleep duration.
// - Wait wake delay before calibration starts.
// - Automatic: swap at end, then sleep.
// - Manual: sleep while trigger high.
// - Manual: trigger low wakes, then calibrates.
// - Manual: swap when done and trigger high.
// - Status select 1 drives finished on pin.
// - Foreground offset runs once in foreground.
// - Background offset repeats every background pass.
// - System keeps input free of DC.
// - Foreground offset first gives one-shot offset.
// - Controller never writes trims during offset.
// - Controller reads trims after done only.
// - Foreground offset plus background: all six.
// - Spare reference: spare offset is reference.
// - Trigger from pin or soft bit.
`include "abc_params.svh"
module abc_cal_dev #(
   parameter int CHANNELS   = 4,                // 1, 2 or 4
   parameter int CAL_CYCLES = `ABC_CAL_CYCLES,  // Calibration length
   parameter int UNIT_CYCLES = `ABC_UNIT_CYCLES // Delay unit length
) (
   input  wire logic                      core_clk,   // Core clock
   input  wire logic                      reset,      // Sync reset
   abc_cal_if.dev                         link,       // Controller link
   input  wire logic                      sampleTick, // Sample boundary
   output abc_pkg::abc_core_mask_type     activeMask, // Cores in service
   output abc_pkg::abc_core_mask_type     poweredMask,// Cores powered
   output abc_pkg::abc_core_mask_type     calMask,    // Cores calibrating
   output abc_pkg::abc_core_mask_type     offsetMask, // Offset cal cores
   output logic                           spareRefOn, // Spare is reference
   output logic                           srcSwitch,  // Source swap pulse
   output logic                           muxSwitch   // Output mux pulse
);
   import abc_pkg::*;

   initial begin
      if (!(CHANNELS == 1 || CHANNELS == 2 || CHANNELS == 4))
         $error("CHANNELS must be 1, 2 or 4");
      if (CAL_CYCLES < 1 || CAL_CYCLES > 65535 || UNIT_CYCLES < 1 ||
          UNIT_CYCLES > 65535)
         $error("Cycle counts out of range");
   end

   localparam int NGRP = (CHANNELS == 4) ? 2 : 1;
   localparam logic [15:0] CAL_LAST = 16'(CAL_CYCLES - 1);
   localparam logic [15:0] UNIT_LAST = 16'(UNIT_CYCLES - 1);
   localparam abc_core_mask_type ALL_CORES =
      (CHANNELS == 4) ? 6'h3f : (CHANNELS == 2) ? 6'h07 : 6'h05;

   abc_state_type     state_ff, nxt_state;
   logic [15:0]       cnt_ff, unitDiv_ff;
   logic [7:0]        srcDly_ff, muxDly_ff;
   logic              pinMeta_ff, pinSync_ff, calEnPrev_ff;
   logic              grp_ff;
   abc_slot_type      spare_ff [2];
   abc_slot_type      last_ff [2];
   abc_core_mask_type activeMask_ff, poweredMask_ff, calMask_ff;
   abc_core_mask_type offsetMask_ff;
   logic              spareRefOn_ff, srcSwitch_ff, muxSwitch_ff;
   logic              statusPin_ff, fgDone_ff, finished_ff;

   // Trigger pin arrives from outside; two flops before use
   always_ff @(posedge core_clk) begin
      pinMeta_ff <= reset ? 1'b0 : link.calibrationTriggerPin;
      pinSync_ff <= reset ? 1'b0 : pinMeta_ff;
   end

   // Trigger source and event decode
   wire trig = link.triggerSourceSelect ? pinSync_ff
                                        : link.softCalibrationTrigger;
   wire calEnRise = link.calEnable & ~calEnPrev_ff;
   wire bgRun = link.calEnable & link.backgroundCalEnable;
   wire lowPower = link.lowPowerBackgroundEnable;
   wire manual = lowPower & link.lowPowerPacingSelect;
   wire unitTick = (unitDiv_ff == UNIT_LAST);
   wire calDone = (cnt_ff == CAL_LAST);
   wire swapReady = (cnt_ff >= {8'h00, srcDly_ff}) & sampleTick;

   // Slot to core map: group 0 is {0,1,2}, group 1 is {4,5,3}
   function automatic abc_core_mask_type slotMask(input logic g,
                                                  input abc_slot_type s);
      abc_core_mask_type m;
      m = 6'h00;
      case (s)
         2'd0:    m = g ? 6'h10 : 6'h01;
         2'd1:    m = g ? 6'h20 : 6'h02;
         default: m = g ? 6'h08 : 6'h04;
      endcase
      return m;
   endfunction : slotMask

   // Victim: the active slot that has served longest
   wire abc_slot_type victim = (CHANNELS == 1)
      ? ((spare_ff[grp_ff] == 2'd0) ? 2'd2 : 2'd0)
      : 2'(2'd3 - spare_ff[grp_ff] - last_ff[grp_ff]);
   wire abc_core_mask_type spareNow = slotMask(grp_ff, spare_ff[grp_ff]);
   wire abc_core_mask_type spareAll = slotMask(1'b0, spare_ff[0]) |
      ((NGRP == 2) ? slotMask(1'b1, spare_ff[1]) : 6'h00);
   wire abc_core_mask_type activeNow = ALL_CORES & ~spareAll;
   wire spareAwake = (state_ff == ABC_WAKE) | (state_ff == ABC_BGCAL) |
                     (state_ff == ABC_HOLD) | (state_ff == ABC_SWAP);

   // Next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ABC_IDLE:  if (calEnRise) nxt_state = ABC_FGCAL;
         ABC_FGCAL: if (calDone)
            nxt_state = !bgRun ? ABC_IDLE : lowPower ? ABC_SLEEP : ABC_BGCAL;
         ABC_SLEEP:
            if (manual ? !trig
                       : unitTick && cnt_ff >= {8'h00,
                                      link.spareSleepDuration})
               nxt_state = ABC_WAKE;
         ABC_WAKE:
            if (unitTick && cnt_ff >= {8'h00, link.spareWakeSettleDuration})
               nxt_state = ABC_BGCAL;
         ABC_BGCAL: if (calDone)
            nxt_state = manual ? ABC_HOLD : ABC_SWAP;
         ABC_HOLD:  if (trig) nxt_state = ABC_SWAP;
         ABC_SWAP:  if (swapReady)
            nxt_state = lowPower ? ABC_SLEEP : ABC_BGCAL;
         default:   nxt_state = ABC_IDLE;
      endcase
      if (!bgRun && state_ff != ABC_IDLE && state_ff != ABC_FGCAL)
         nxt_state = ABC_IDLE;
   end

   // State, counters and link-side flags
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_ff     <= ABC_IDLE;
         cnt_ff       <= 16'h0000;
         unitDiv_ff   <= 16'h0000;
         calEnPrev_ff <= 1'b0;
         fgDone_ff    <= 1'b0;
         finished_ff  <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         calEnPrev_ff <= link.calEnable;
         unitDiv_ff   <= (unitTick || nxt_state != state_ff)
                         ? 16'h0000 : 16'(unitDiv_ff + 16'h0001);
         if (nxt_state != state_ff)
            cnt_ff <= 16'h0000;
         else if (state_ff == ABC_FGCAL || state_ff == ABC_BGCAL ||
                  state_ff == ABC_SWAP || unitTick)
            cnt_ff <= 16'(cnt_ff + 16'h0001);
         // Set wins over a clear in the same cycle
         if (state_ff == ABC_FGCAL && calDone)
            fgDone_ff <= 1'b1;
         else if (calEnRise)
            fgDone_ff <= 1'b0;
         // Finished: from end of calibration until the swap
         if (state_ff == ABC_BGCAL && calDone)
            finished_ff <= 1'b1;
         else if (nxt_state != ABC_HOLD && nxt_state != ABC_SWAP)
            finished_ff <= 1'b0;
      end
   end

   // Spare rotation per group, committed on a sample boundary
   always_ff @(posedge core_clk) begin
      if (reset) begin
         grp_ff     <= 1'b0;
         spare_ff   <= '{2'd2, 2'd2};
         last_ff    <= '{2'd1, 2'd1};
      end else if (state_ff == ABC_SWAP && swapReady) begin
         spare_ff[grp_ff] <= victim;
         last_ff[grp_ff]  <= spare_ff[grp_ff];
         grp_ff           <= (NGRP == 2) ? ~grp_ff : 1'b0;
      end
   end

   // Device registers written over the link
   always_ff @(posedge core_clk) begin
      if (reset) begin
         srcDly_ff <= `ABC_RST_CORE_SRC_DLY;
         muxDly_ff <= `ABC_RST_OUT_SEL_DLY;
      end else if (link.regWrite) begin
         if (link.regAddr == `ABC_REG_CORE_SRC_DLY)
            srcDly_ff <= link.regWdata;
         if (link.regAddr == `ABC_REG_OUT_SEL_DLY)
            muxDly_ff <= link.regWdata;
      end
   end

   // Core masks; one calibrating core at a time in background
   wire abc_core_mask_type calNext =
      (state_ff == ABC_FGCAL) ? activeNow :
      (state_ff == ABC_BGCAL) ? spareNow : 6'h00;
   wire abc_core_mask_type offsetNext =
      (state_ff == ABC_FGCAL && link.foregroundOffsetEnable)
         ? (link.backgroundCalEnable ? ALL_CORES : activeNow)
      : (state_ff == ABC_BGCAL && link.backgroundOffsetEnable)
         ? spareNow : 6'h00;
   wire abc_core_mask_type poweredNext = !lowPower ? ALL_CORES :
      activeNow | (spareAwake ? spareNow : 6'h00);
   wire statusNext = link.statusPinSelect & finished_ff;

   // Registered outputs
   always_ff @(posedge core_clk) begin
      if (reset) begin
         activeMask_ff  <= 6'h00;
         poweredMask_ff <= 6'h00;
         calMask_ff     <= 6'h00;
         offsetMask_ff  <= 6'h00;
         spareRefOn_ff  <= 1'b0;
         srcSwitch_ff   <= 1'b0;
         muxSwitch_ff   <= 1'b0;
         statusPin_ff   <= 1'b0;
      end else begin
         activeMask_ff  <= activeNow;
         poweredMask_ff <= poweredNext;
         calMask_ff     <= calNext;
         offsetMask_ff  <= offsetNext;
         spareRefOn_ff  <= link.spareOffsetReference & bgRun;
         srcSwitch_ff   <= state_ff == ABC_SWAP && swapReady;
         muxSwitch_ff   <= state_ff == ABC_SWAP &&
                           cnt_ff == {8'h00, muxDly_ff};
         statusPin_ff   <= statusNext;
      end
   end

   assign activeMask  = activeMask_ff;
   assign poweredMask = poweredMask_ff;
   assign calMask     = calMask_ff;
   assign offsetMask  = offsetMask_ff;
   assign spareRefOn  = spareRefOn_ff;
   assign srcSwitch   = srcSwitch_ff;
   assign muxSwitch   = muxSwitch_ff;
   assign link.calibrationStatusPin = statusPin_ff;
   assign link.foregroundDoneFlag   = fgDone_ff;
endmodule : abc_cal_dev

// >>> pkg/abc_params.svh
/*
 Shared constants of the background calibration sequencer: register
 offsets, field positions, reset values and timing counts.
 Assumes a 100 MHz core_clk; included by bare name.
*/
`ifndef ABC_PARAMS_SVH
`define ABC_PARAMS_SVH

// Clock and timing figures
`define ABC_CLK_NS          10
`define ABC_UNIT_TIME_NS    10240
`define ABC_UNIT_CYCLES     (`ABC_UNIT_TIME_NS / `ABC_CLK_NS)
`define ABC_CAL_TIME_NS     81920
`define ABC_CAL_CYCLES      (`ABC_CAL_TIME_NS / `ABC_CLK_NS)

// Device registers on the link
`define ABC_REG_CORE_SRC_DLY   8'h9a
`define ABC_REG_OUT_SEL_DLY    8'h9b
`define ABC_RST_CORE_SRC_DLY   8'h1f
`define ABC_RST_OUT_SEL_DLY    8'h1e

// Controller registers on APB
`define ABC_APB_CTRL        12'h000
`define ABC_APB_DELAY       12'h004
`define ABC_APB_STATUS      12'h008
`define ABC_APB_SWAPDLY     12'h00c

// Control register fields
`define ABC_CTRL_CAL_EN     0
`define ABC_CTRL_BG_EN      1
`define ABC_CTRL_TRIG_SEL   2
`define ABC_CTRL_SOFT_TRIG  3
`define ABC_CTRL_LOW_POWER_BACKGROUND_ENABLE      4
`define ABC_CTRL_LP_PACE    5
`define ABC_CTRL_STAT_SEL   6
`define ABC_CTRL_FG_OFS     7
`define ABC_CTRL_BG_OFS     8
`define ABC_CTRL_SPARE_REF  9
`define ABC_CTRL_PIN_TRIG   10
`define ABC_CTRL_WIDTH      11
`define ABC_CTRL_RESET      11'h008

// Delay register fields and reset values
`define ABC_DLY_SLEEP_LSB   0
`define ABC_DLY_WAKE_LSB    8
`define ABC_RST_SLEEP       8'h10
`define ABC_RST_WAKE        8'h02

`endif

// >>> pkg/abc_pkg.sv
/*
 Types of the background calibration sequencer.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package abc_pkg;

   // Sequencer states, one-hot
   typedef enum logic [6:0] {
      ABC_IDLE  = 7'h01,
      ABC_FGCAL = 7'h02,
      ABC_SLEEP = 7'h04,
      ABC_WAKE  = 7'h08,
      ABC_BGCAL = 7'h10,
      ABC_HOLD  = 7'h20,
      ABC_SWAP  = 7'h40
   } abc_state_type;

   typedef logic [5:0] abc_core_mask_type;
   typedef logic [1:0] abc_slot_type;

endpackage : abc_pkg

// >>> pkg/abc_cal_if.sv
/*
 Link between system controller and calibration sequencer.
 Assumes both ends on core_clk; the trigger pin is treated as asynchronous.
*/
`timescale 1ns/1ns
interface abc_cal_if;
   logic       calEnable;        // Starts foreground pass on rise
   logic       backgroundCalEnable;
   logic       triggerSourceSelect; // 1: pin, 0: soft bit
   logic       softCalibrationTrigger;
   logic       calibrationTriggerPin;
   logic       lowPowerBackgroundEnable;
   logic       lowPowerPacingSelect; // 1: manual
   logic [7:0] spareSleepDuration;
   logic [7:0] spareWakeSettleDuration;
   logic       statusPinSelect;
   logic       foregroundOffsetEnable;
   logic       backgroundOffsetEnable;
   logic       spareOffsetReference;
   logic       regWrite;         // One-cycle device register write
   logic [7:0] regAddr;
   logic [7:0] regWdata;
   logic       calibrationStatusPin;
   logic       foregroundDoneFlag;

   modport dev (
      input  calEnable, backgroundCalEnable, triggerSourceSelect,
             softCalibrationTrigger, calibrationTriggerPin,
             lowPowerBackgroundEnable, lowPowerPacingSelect,
             spareSleepDuration, spareWakeSettleDuration, statusPinSelect,
             foregroundOffsetEnable, backgroundOffsetEnable,
             spareOffsetReference, regWrite, regAddr, regWdata,
      output calibrationStatusPin, foregroundDoneFlag
   );
   modport ctl (
      output calEnable, backgroundCalEnable, triggerSourceSelect,
             softCalibrationTrigger, calibrationTriggerPin,
             lowPowerBackgroundEnable, lowPowerPacingSelect,
             spareSleepDuration, spareWakeSettleDuration, statusPinSelect,
             foregroundOffsetEnable, backgroundOffsetEnable,
             spareOffsetReference, regWrite, regAddr, regWdata,
      input  calibrationStatusPin, foregroundDoneFlag
   );
endinterface : abc_cal_if

// >>> rtl/abc_cal_ctl.sv
/*
 Controller end: APB slave whose registers drive the calibration link.
 Assumes an APB master on core_clk; the status pin is resynchronised.
*/
`timescale 1ns/1ns
`include "abc_params.svh"
module abc_cal_ctl (
   input  wire logic        core_clk,  // Core clock
   input  wire logic        reset,     // Sync reset
   input  wire logic        psel,      // APB select
   input  wire logic        penable,   // APB access phase
   input  wire logic        pwrite,    // APB direction
   input  wire logic [11:0] paddr,     // APB byte address
   input  wire logic [31:0] pwdata,    // APB write data
   output logic      [31:0] prdata,    // APB read data
   output logic             pready,    // APB ready
   output logic             pslverr,   // Unmapped address
   abc_cal_if.ctl           link       // Device link
);
   import abc_pkg::*;

   logic [`ABC_CTRL_WIDTH-1:0] ctrl_ff;
   logic [7:0]  sleep_ff, wake_ff, srcDly_ff, muxDly_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff, pslverr_ff, regWrite_ff;
   logic [7:0]  regAddr_ff, regWdata_ff;
   logic        statMeta_ff, statSync_ff;

   // Status pin crosses from the device; two flops
   always_ff @(posedge core_clk) begin
      statMeta_ff <= reset ? 1'b0 : link.calibrationStatusPin;
      statSync_ff <= reset ? 1'b0 : statMeta_ff;
   end

   // Address decode; one wait state so read data comes from a flop
   wire access  = psel & penable & ~pready_ff;
   wire commit  = psel & penable & pready_ff;
   wire hitCtrl = paddr == `ABC_APB_CTRL;
   wire hitDly  = paddr == `ABC_APB_DELAY;
   wire hitStat = paddr == `ABC_APB_STATUS;
   wire hitSwap = paddr == `ABC_APB_SWAPDLY;
   wire mapped  = hitCtrl | hitDly | hitStat | hitSwap;
   wire wrOk    = commit & pwrite & mapped;
   wire [31:0] rdMux =
      hitCtrl ? {21'h000000, ctrl_ff} :
      hitDly  ? {16'h0000, wake_ff, sleep_ff} :
      hitStat ? {30'h00000000, statSync_ff,
                 link.foregroundDoneFlag} :
      hitSwap ? {16'h0000, muxDly_ff, srcDly_ff} : 32'h00000000;

   // Bus answer
   always_ff @(posedge core_clk) begin
      if (reset) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h00000000;
      end else begin
         pready_ff  <= access;
         pslverr_ff <= access & ~mapped;
         prdata_ff  <= (access & ~pwrite) ? rdMux : 32'h00000000;
      end
   end

   // Control and delay registers; writes land at the ready edge
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctrl_ff  <= `ABC_CTRL_RESET;
         sleep_ff <= `ABC_RST_SLEEP;
         wake_ff  <= `ABC_RST_WAKE;
      end else begin
         if (wrOk && hitCtrl)
            ctrl_ff <= pwdata[`ABC_CTRL_WIDTH-1:0];
         if (wrOk && hitDly) begin
            sleep_ff <= pwdata[`ABC_DLY_SLEEP_LSB +: 8];
            wake_ff  <= pwdata[`ABC_DLY_WAKE_LSB +: 8];
         end
      end
   end

   // Swap delays mirrored and forwarded; reset loads them with no link write
   always_ff @(posedge core_clk) begin
      if (reset) begin
         srcDly_ff   <= `ABC_RST_CORE_SRC_DLY;
         muxDly_ff   <= `ABC_RST_OUT_SEL_DLY;
         regWrite_ff <= 1'b0;
         regAddr_ff  <= 8'h00;
         regWdata_ff <= 8'h00;
      end else if (wrOk && hitSwap && pwdata[7:0] != srcDly_ff) begin
         // A changed source byte takes two link writes, source then mux
         srcDly_ff   <= pwdata[7:0];
         regWrite_ff <= 1'b1;
         regAddr_ff  <= `ABC_REG_CORE_SRC_DLY;
         regWdata_ff <= pwdata[7:0];
         muxDly_ff   <= pwdata[15:8];
      end else if (regWrite_ff && regAddr_ff == `ABC_REG_CORE_SRC_DLY) begin
         regAddr_ff  <= `ABC_REG_OUT_SEL_DLY;
         regWdata_ff <= muxDly_ff;
      end else if (wrOk && hitSwap) begin
         muxDly_ff   <= pwdata[15:8];
         regWrite_ff <= 1'b1;
         regAddr_ff  <= `ABC_REG_OUT_SEL_DLY;
         regWdata_ff <= pwdata[15:8];
      end else begin
         regWrite_ff <= 1'b0;
      end
   end

   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;
   assign link.calEnable                = ctrl_ff[`ABC_CTRL_CAL_EN];
   assign link.backgroundCalEnable      = ctrl_ff[`ABC_CTRL_BG_EN];
   assign link.triggerSourceSelect      = ctrl_ff[`ABC_CTRL_TRIG_SEL];
   assign link.softCalibrationTrigger   = ctrl_ff[`ABC_CTRL_SOFT_TRIG];
   assign link.calibrationTriggerPin    = ctrl_ff[`ABC_CTRL_PIN_TRIG];
   assign link.lowPowerBackgroundEnable = ctrl_ff[`ABC_CTRL_LOW_POWER_BACKGROUND_ENABLE];
   assign link.lowPowerPacingSelect     = ctrl_ff[`ABC_CTRL_LP_PACE];
   assign link.statusPinSelect          = ctrl_ff[`ABC_CTRL_STAT_SEL];
   assign link.foregroundOffsetEnable   = ctrl_ff[`ABC_CTRL_FG_OFS];
   assign link.backgroundOffsetEnable   = ctrl_ff[`ABC_CTRL_BG_OFS];
   assign link.spareOffsetReference     = ctrl_ff[`ABC_CTRL_SPARE_REF];
   assign link.spareSleepDuration       = sleep_ff;
   assign link.spareWakeSettleDuration  = wake_ff;
   assign link.regWrite                 = regWrite_ff;
   assign link.regAddr                  = regAddr_ff;
   assign link.regWdata                 = regWdata_ff;
endmodule : abc_cal_ctl

// >>> verif/abc_cal_props.sv
/*
 Checker of the calibration link and of the device's core masks.
 Assumes one core_clk domain with a synchronous active-high reset.
*/
`timescale 1ns/1ns
module abc_cal_props (
   input wire logic                   core_clk,              // Clock
   input wire logic                   reset,                 // Reset
   input wire logic                   calEnable,             // Cal on
   input wire logic                   statusPinSelect,       // Pin select
   input wire logic                   calibrationStatusPin,  // Status pin
   input wire logic                   foregroundDoneFlag,    // Foreground_done_flag
   input wire logic                   foregroundOffsetEnable, // Fg offset
   input wire logic                   backgroundOffsetEnable, // Bg offset
   input wire logic                   spareOffsetReference,  // Spare ref
   input wire logic                   sampleTick,            // Boundary
   input wire abc_pkg::abc_core_mask_type activeMask,        // In service
   input wire abc_pkg::abc_core_mask_type poweredMask,       // Powered
   input wire abc_pkg::abc_core_mask_type calMask,           // Calibrating
   input wire abc_pkg::abc_core_mask_type offsetMask,        // Offset cal
   input wire logic                   spareRefOn,            // Ref in use
   input wire logic                   srcSwitch              // Swap pulse
);
   localparam int FG_MAX = 40;
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);

   // Several calibrating cores only as the foreground set 6'h33, cores 0, 1, 4 and 5
   property p_one_cal;
      $countones(calMask) > 1 |-> calMask == 6'h33;
   endproperty
   a_one_cal: assert property (p_one_cal)
      else $error("more than one core calibrating");
   // Pin stays low unless its select bit was set
   property p_stat_pin;
      !$past(statusPinSelect) |-> !calibrationStatusPin;
   endproperty
   a_stat_pin: assert property (p_stat_pin)
      else $error("status pin driven while not selected");
   // Swap only right after a sample boundary
   property p_swap_tick;
      srcSwitch |-> $past(sampleTick) || $past(sampleTick, 2);
   endproperty
   a_swap_tick: assert property (p_swap_tick)
      else $error("swap away from a sample boundary");
   // Cores in service change only at a swap
   property p_active_swap;
      $changed(activeMask) |->
         $past(reset, 2) || srcSwitch || $past(srcSwitch);
   endproperty
   a_active_swap: assert property (p_active_swap)
      else $error("active cores changed without a swap");
   // A core under calibration must be awake
   property p_cal_powered;
      (calMask & ~poweredMask) == 6'h00;
   endproperty
   a_cal_powered: assert property (p_cal_powered)
      else $error("calibrating a powered-down core");
   property p_spare_ref;
      spareRefOn |-> $past(spareOffsetReference) && $past(calEnable);
   endproperty
   a_spare_ref: assert property (p_spare_ref)
      else $error("spare reference without its enable");
   property p_offset_en;
      offsetMask != 6'h00 |->
         $past(foregroundOffsetEnable) || $past(backgroundOffsetEnable);
   endproperty
   a_offset_en: assert property (p_offset_en)
      else $error("offset calibration without an enable");
   // Foreground pass restarts and ends within a bounded time
   property p_foreground_done_flag;
      $rose(calEnable) |-> ##3 !foregroundDoneFlag
         ##[1:FG_MAX] foregroundDoneFlag;
   endproperty
   a_foreground_done_flag: assert property (p_foreground_done_flag)
      else $error("foreground pass did not complete");
endmodule : abc_cal_props

// >>> verif/tb.sv
/*
 Testbench: APB master on the controller, device behind the link,
 and a queue model of core rotation. Assumes 4 channels.
*/
`timescale 1ns/1ns
module tb;
   import abc_pkg::*;
   logic              core_clk = 0, reset = 1, sampleTick = 0;
   logic              psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [11:0]       paddr = '0;
   logic [31:0]       pwdata = '0, prdata, rdVal;
   logic              errFlag;
   logic [1:0]        tick = '0;
   logic [7:0]        lfsr = 8'h60;
   abc_core_mask_type activeMask, poweredMask, calMask, offsetMask;
   logic              spareRefOn, srcSwitch, muxSwitch;
   int                errors = 0, samples_checked = 0;
   int                actQ[2][$];
   int                spare[2], grp;

   abc_cal_if link();
   abc_cal_ctl abc_cal_ctl_i (.core_clk, .reset, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .link(link));
   abc_cal_dev #(.CHANNELS(4), .CAL_CYCLES(16), .UNIT_CYCLES(4))
      abc_cal_dev_i (.core_clk, .reset, .link(link), .sampleTick,
      .activeMask, .poweredMask, .calMask, .offsetMask, .spareRefOn,
      .srcSwitch, .muxSwitch);
   abc_cal_props abc_cal_props_i (.core_clk, .reset,
      .calEnable(link.calEnable), .statusPinSelect(link.statusPinSelect),
      .calibrationStatusPin(link.calibrationStatusPin),
      .foregroundDoneFlag(link.foregroundDoneFlag),
      .foregroundOffsetEnable(link.foregroundOffsetEnable),
      .backgroundOffsetEnable(link.backgroundOffsetEnable),
      .spareOffsetReference(link.spareOffsetReference), .sampleTick,
      .activeMask, .poweredMask, .calMask, .offsetMask, .spareRefOn,
      .srcSwitch);

   // Clock and a sample boundary every fourth cycle
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      tick <= tick + 2'h1;
      sampleTick <= (tick == 2'h2);
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Next pseudo-random byte
   function automatic logic [7:0] nxtLfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : nxtLfsr

   // One APB transfer; only the watchdog ends the wait
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rdVal = prdata;
      errFlag = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb

   function automatic logic [31:0] modelMask();
      logic [31:0] m;
      m = '0;
      foreach (actQ[g, i]) m[actQ[g][i]] = 1'b1;
      return m;
   endfunction : modelMask

   // Rotation restarts from cores 2 and 3 after every reset
   task automatic doReset();
      reset <= 1'b1;
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      actQ[0] = '{0, 1}; actQ[1] = '{4, 5}; spare = '{2, 3}; grp = 0;
      repeat (2) @(posedge core_clk);
      chk(activeMask, modelMask());
   endtask : doReset

   // Longest-serving core of the current group goes out
   task automatic waitSwap();
      int n, v;
      logic muxSeen;
      n = 0;
      muxSeen = 1'b0;
      while (srcSwitch !== 1'b1 && n < 3000) begin
         @(posedge core_clk);
         n++;
         if (muxSwitch === 1'b1) muxSeen = 1'b1;
      end
      if (n == 3000) errors++;
      repeat (2) @(posedge core_clk);
      v = actQ[grp].pop_front();
      actQ[grp].push_back(spare[grp]);
      spare[grp] = v;
      grp ^= 1;
      chk(activeMask, modelMask());
      chk(muxSeen, 1'b1);
   endtask : waitSwap

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize

   // Watchdog well beyond the expected run
   initial begin
      repeat (30000) @(posedge core_clk);
      errors++;
      summarize();
   end

   initial begin
      doReset();
      apb(0, 12'h000, 0); chk(rdVal, 32'h008);
      apb(0, 12'h004, 0); chk(rdVal, 32'h0210);
      apb(0, 12'h010, 0);
      chk(errFlag, 1'b1);
      chk(rdVal, 32'h0);
      lfsr = nxtLfsr(lfsr);
      apb(1, 12'h004, {16'h0, 4'h0, lfsr[3:0], 4'h0, lfsr[7:4]});
      apb(0, 12'h004, 0); chk(rdVal, {16'h0, 4'h0, lfsr[3:0], 4'h0, lfsr[7:4]});
      apb(1, 12'h00c, 32'h1e1f);
      apb(0, 12'h00c, 0); chk(rdVal, 32'h1e1f);
      $display("test 1 done");
      // Plain background rotation, groups alternating
      apb(1, 12'h000, 32'h34b);
      repeat (3) waitSwap();
      apb(0, 12'h008, 0); chk(rdVal[0], 1'b1);
      $display("test 2 done");
      // Automatic low-power pacing with foreground offset
      doReset();
      apb(1, 12'h000, 32'h09b);
      repeat (2) waitSwap();
      $display("test 3 done");
      // Manual pacing on the trigger pin
      doReset();
      apb(1, 12'h000, 32'h477);
      repeat (100) @(posedge core_clk);
      chk(poweredMask & 6'h0c, 6'h00);
      apb(1, 12'h000, 32'h077);
      repeat (150) @(posedge core_clk);
      chk(poweredMask & 6'h04, 6'h04);
      chk(activeMask, modelMask());
      apb(0, 12'h008, 0);
      chk(rdVal, 32'h3);
      apb(1, 12'h000, 32'h477);
      waitSwap();
      $display("test 4 done");
      summarize();
   end
endmodule : tb
